// >>> shared/bridge_pkg.sv
package bridge_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int REG_AW = 12;
  localparam logic [11:0] OFS_MISC = 12'h184; // coupled timer, compat
  localparam logic [11:0] OFS_SPECIAL = 12'h188; // special image
  localparam logic [11:0] OFS_CMD_ERR = 12'h18c; // command error log
  localparam logic [11:0] OFS_ADDR_ERR = 12'h190; // address error log
  localparam logic [11:0] OFS_IMG4_CTL = 12'h1a0; // image 4 control
  localparam logic [11:0] OFS_IMG4_BASE = 12'h1a4; // image 4 base
  localparam logic [11:0] OFS_IMG4_BOUND = 12'h1a8; // image 4 bound
  localparam logic [11:0] OFS_IMG4_OFS = 12'h1b0; // image 4 offset

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POS_COMPAT = 28; // misc [31:28]
  localparam int POS_CWT = 24; // misc [26:24]
  localparam int POS_EN = 31; // image enable
  localparam int POS_POSTED_WRITE_ENABLE = 30; // posted write enable
  localparam int POS_SP_WIDTH = 20; // special [23:20]
  localparam int POS_SP_PGM = 12; // special [15:12]
  localparam int POS_SP_SUPER = 8; // special [11:8]
  localparam int POS_SP_BASE = 2; // special [7:2]
  localparam int POS_LAS = 0; // pci space select
  localparam int POS_CMD = 28; // logged command [31:28]
  localparam int POS_MERR = 27; // multiple error flag
  localparam int POS_LVALID = 23; // log valid flag
  localparam int POS_I4_WIDTH = 22; // image 4 [23:22]
  localparam int POS_I4_SPACE = 16; // image 4 [18:16]
  localparam int POS_I4_PGM = 14; // program/data
  localparam int POS_I4_SUPER = 12; // supervisor
  localparam int POS_I4_VCT = 8; // block cycle type
  localparam int POS_PAGE = 12; // 4 KB page field [31:12]

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0] RST_CMD = 4'h7; // logged command after reset
  localparam logic [1:0] RST_I4_WIDTH = 2'h2; // 32-bit

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] W8 = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;
  localparam logic [1:0] W64 = 2'h3;
  localparam logic [2:0] SP_A16 = 3'h0;
  localparam logic [2:0] SP_A24 = 3'h1;
  localparam logic [2:0] SP_A32 = 3'h2;
  localparam logic [2:0] SP_CRCSR = 3'h5;
  localparam logic [2:0] SP_USER1 = 3'h6;
  localparam logic [2:0] SP_USER2 = 3'h7;
  localparam logic [7:0] A16_TOP = 8'hff; // top 64 KB of a region
  localparam logic [5:0] AM_USER1 = 6'h10; // user codes, plain picks
  localparam logic [5:0] AM_USER2 = 6'h11;
  localparam logic [5:0] AM_CRCSR = 6'h2f;
  localparam logic [5:0] AM_NONE = 6'h00; // reserved space

  // ------------------------------------------------------------
  // coupled window hold times, in clocks
  // ------------------------------------------------------------
  localparam int WIN_W = 10;
  localparam logic [WIN_W-1:0] WIN_16 = 10'h010;
  localparam logic [WIN_W-1:0] WIN_32 = 10'h020;
  localparam logic [WIN_W-1:0] WIN_64 = 10'h040;
  localparam logic [WIN_W-1:0] WIN_128 = 10'h080;
  localparam logic [WIN_W-1:0] WIN_246 = 10'h0f6;
  localparam logic [WIN_W-1:0] WIN_512 = 10'h200;

endpackage : bridge_pkg

// >>> shared/window_if.sv
`timescale 1ns/100ps
// carries coupled-cycle events to the window timer and ownership back
interface window_if;
  logic start; // coupled transaction begins
  logic done; // coupled transaction processed
  logic [2:0] code; // hold time select
  logic own; // vme ownership held

  modport ctl (output start, output done, output code, input own);
  modport tmr (input start, input done, input code, output own);
endinterface : window_if

// >>> hw/coupled_timer.sv
`timescale 1ns/100ps
module coupled_timer
  import bridge_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  window_if.tmr win // events in, ownership out
);

  typedef enum logic [2:0] {
    IDLE = 3'b001, BUSY = 3'b010, HOLD = 3'b100
  } tstate_t;

  typedef struct packed {
    tstate_t st; // phase
    logic [WIN_W-1:0] cnt; // clocks left in window
    logic own; // ownership flag
  } tmr_t;

  tmr_t r, nxt;

  // ------------------------------------------------------------
  // hold time decode
  // ------------------------------------------------------------
  function automatic logic [WIN_W-1:0] limit(input logic [2:0] c);
    case (c)
      3'h1: limit = WIN_16;
      3'h2: limit = WIN_32;
      3'h3: limit = WIN_64;
      3'h4: limit = WIN_128;
      3'h5: limit = WIN_246;
      3'h6: limit = WIN_512;
      default: limit = '0; // 000 and reserved code release at once
    endcase
  endfunction : limit

  // next state
  always_comb begin
    nxt = r;
    case (r.st)
      IDLE, HOLD: begin
        if (win.start) begin
          nxt.st = BUSY; // grab or keep ownership
          nxt.own = 1'b1;
        end else if (r.st == HOLD && r.cnt <= 1) begin
          nxt.st = IDLE; // window ran out: release
          nxt.own = 1'b0;
          nxt.cnt = '0;
        end else if (r.st == HOLD) begin
          nxt.cnt = r.cnt - 1'b1;
        end
      end
      BUSY: begin
        if (win.done) begin
          nxt.cnt = limit(win.code); // restart timer
          if (limit(win.code) == '0) begin
            nxt.st = IDLE; // release after first
            nxt.own = 1'b0;
          end else begin
            nxt.st = HOLD; // hold for chosen clocks
          end
        end
      end
      default: nxt = '{st: IDLE, cnt: '0, own: 1'b0};
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '{st: IDLE, cnt: '0, own: 1'b0};
    end else if (ce_i) begin
      r <= nxt;
    end
  end

  assign win.own = r.own;

endmodule : coupled_timer

// >>> hw/error_log.sv
`timescale 1ns/100ps
module error_log
  import bridge_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire logic err_i, // posted write failed, pulse
  input wire logic [3:0] cmd_i, // failing command
  input wire logic [31:0] addr_i, // failing start address
  input wire logic clr_i, // software re-arm, pulse
  output logic valid_o, // logs valid and frozen
  output logic merr_o, // more errors since freeze
  output logic [3:0] cmd_o, // logged command
  output logic [31:0] addr_o // logged address
);

  typedef struct packed {
    logic valid;
    logic merr;
    logic [3:0] cmd;
    logic [31:0] addr;
  } log_t;

  log_t r, nxt;

  // capture while armed, flag overflow while frozen
  always_comb begin
    nxt = r;
    if (clr_i) begin
      nxt.valid = 1'b0; // re-arm
      nxt.merr = 1'b0;
    end
    // an error in the clearing cycle is caught, not lost
    if (err_i && (!r.valid || clr_i)) begin
      nxt.valid = 1'b1;
      nxt.cmd = cmd_i;
      nxt.addr = addr_i;
    end else if (err_i) begin
      nxt.merr = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '{valid: 1'b0, merr: 1'b0, cmd: RST_CMD, addr: '0};
    end else if (ce_i) begin
      r <= nxt;
    end
  end

  assign valid_o = r.valid;
  assign merr_o = r.merr;
  assign cmd_o = r.cmd;
  assign addr_o = r.addr;

endmodule : error_log

// >>> hw/slave_image_ctrl.sv
// Overview of operation
// - window code picks hold time or release
// - each coupled transaction restarts the window timer
// - timer expiry releases vme ownership
// - compat field stored, otherwise ignored
// - special image claims pci bits 31:26 match
// - other images win over the special image
// - pci bits 25:24 pick special region
// - top 64 KB per region goes A16
// - per-region width, program and supervisor bits
// - A16 part ignores program/data bit
// - special image never emits block codes
// - failed posted writes log their command
// - failed posted writes log start address
// - valid flag freezes log, write one rearms
// - extra error while frozen sets multiple flag
// - logged command resets to 0111
// - io space image 4 forces coupled
// - image 4 width codes, resets 32-bit
// - image 4 vme space codes
// - block bit only for A24/A32 narrow widths
// - A24/A32 with 64-bit allows MBLT
// - decode base to bound, zero bound open
// - image 4 uses 4 KB pages
// - image 4 vme address adds offset
`timescale 1ns/100ps
module slave_image_ctrl
  import bridge_pkg::*;
(
  input wire logic clk_i, // 200 MHz pci clock
  input wire logic arst_n_i, // async reset, low
  input wire logic ce_i, // clock enable, freezes all
  input wire logic [REG_AW-1:0] reg_addr_i, // register byte address
  input wire logic [31:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [31:0] reg_rdata_o, // read data, cycle after
  input wire logic req_i, // pci address phase, pulse
  input wire logic [31:0] pci_addr_i, // pci address
  input wire logic pci_io_i, // 1 = io space, 0 = memory
  input wire logic other_hit_i, // a higher image also hits
  output logic dec_valid_o, // decode result valid, pulse
  output logic claim_special_o, // special image claims
  output logic claim_img4_o, // image 4 claims
  output logic posted_o, // write may be posted
  output logic [31:0] vme_addr_o, // translated vme address
  output logic [5:0] vme_am_o, // address modifier
  output logic [1:0] vme_width_o, // max data width code
  output logic block_ok_o, // block transfers allowed
  output logic mblt_ok_o, // 64-bit block allowed
  input wire logic coup_start_i, // coupled transaction starts
  input wire logic coup_done_i, // coupled transaction done
  output logic vme_own_o, // vme ownership held
  input wire logic err_i, // posted write error, pulse
  input wire logic [3:0] err_cmd_i, // failing command
  input wire logic [31:0] err_addr_i // failing start address
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] compat; // legacy field, no effect
    logic [2:0] coupled_window_timer; // coupled window code
    logic sp_en; // special image enable
    logic sp_posted_write_enable; // special posted writes
    logic [3:0] sp_width; // per region 0=16 1=32
    logic [3:0] sp_pgm; // per region program
    logic [3:0] sp_super; // per region supervisor
    logic [5:0] sp_base; // 64 MB base
    logic sp_las; // special pci space
    logic i4_en; // image 4 enable
    logic i4_posted_write_enable; // image 4 posted writes
    logic [1:0] i4_width; // image 4 max width
    logic [2:0] i4_space; // image 4 vme space
    logic i4_pgm; // image 4 program
    logic i4_super; // image 4 supervisor
    logic i4_vct; // image 4 block cycles
    logic i4_las; // image 4 pci space
    logic [19:0] i4_base; // 4 KB page base
    logic [19:0] i4_bound; // 4 KB page bound
    logic [19:0] i4_ofs; // 4 KB page offset
    logic [31:0] rdata; // read data register
    logic dvalid; // decode valid pulse
    logic c_sp; // special claim
    logic c_i4; // image 4 claim
    logic posted; // posting allowed
    logic [31:0] vaddr; // vme address
    logic [5:0] am; // address modifier
    logic [1:0] vwidth; // width code
    logic blk; // block allowed
    logic mblt; // mblt allowed
  } ctl_t;

  ctl_t r, nxt;

  // error log view
  logic log_valid; // logs valid
  logic log_merr; // multiple errors
  logic [3:0] log_cmd; // logged command
  logic [31:0] log_addr; // logged address
  logic log_clr; // software re-arm pulse

  // decode terms
  logic sp_hit; // special image hit
  logic i4_hit; // image 4 hit
  logic [1:0] region; // special region index
  logic sp_a16; // special access in A16 part
  logic [19:0] page; // incoming 4 KB page
  logic i4_wide; // A24 or A32 selected

  window_if win ();

  // ------------------------------------------------------------
  // address modifier encoding
  // ------------------------------------------------------------
  function automatic logic [5:0] am_code(input logic [2:0] sp,
                                         input logic sup,
                                         input logic program_data_select,
                                         input logic blt,
                                         input logic mb);
    logic [5:0] base;
    base = 6'h00;
    case (sp)
      SP_A16: base = sup ? 6'h2d : 6'h29; // pgm unused
      SP_A24, SP_A32: begin
        base = (sp == SP_A24) ? 6'h38 : 6'h08;
        if (sup) begin
          base = base | 6'h04;
        end
        if (mb) begin
          base = base | 6'h00; // 64-bit block code
        end else if (blt) begin
          base = base | 6'h03; // block code
        end else begin
          base = base | (program_data_select ? 6'h02 : 6'h01);
        end
      end
      SP_CRCSR: base = AM_CRCSR;
      SP_USER1: base = AM_USER1;
      SP_USER2: base = AM_USER2;
      default: base = AM_NONE; // reserved spaces
    endcase
    am_code = base;
  endfunction : am_code

  // register index match
  function automatic logic at(input logic [REG_AW-1:0] a,
                              input logic [REG_AW-1:0] o);
    at = (a == o);
  endfunction : at

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  assign win.start = coup_start_i;
  assign win.done = coup_done_i;
  assign win.code = r.coupled_window_timer; // software keeps it steady

  coupled_timer u_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .win(win)
  );

  assign log_clr = reg_wr_i && at(reg_addr_i, OFS_CMD_ERR)
                   && reg_wdata_i[POS_LVALID]; // zero writes ignored

  error_log u_log (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .err_i(err_i),
    .cmd_i(err_cmd_i),
    .addr_i(err_addr_i),
    .clr_i(log_clr),
    .valid_o(log_valid),
    .merr_o(log_merr),
    .cmd_o(log_cmd),
    .addr_o(log_addr)
  );

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // both windows compare combinationally, results are registered
  always_comb begin
    page = pci_addr_i[31:POS_PAGE];
    region = pci_addr_i[25:24];
    sp_a16 = (pci_addr_i[23:16] == A16_TOP);
    i4_wide = (r.i4_space == SP_A24) || (r.i4_space == SP_A32);
    i4_hit = r.i4_en && (pci_io_i == r.i4_las)
             && (page >= r.i4_base)
             && ((r.i4_bound == '0) || (page < r.i4_bound));
    sp_hit = r.sp_en && (pci_io_i == r.sp_las)
             && (pci_addr_i[31:26] == r.sp_base)
             && !other_hit_i && !i4_hit;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt = r;
    nxt.dvalid = 1'b0;
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_MISC: begin
          nxt.compat = reg_wdata_i[POS_COMPAT +: 4];
          nxt.coupled_window_timer = reg_wdata_i[POS_CWT +: 3];
        end
        OFS_SPECIAL: begin
          nxt.sp_en = reg_wdata_i[POS_EN];
          nxt.sp_posted_write_enable = reg_wdata_i[POS_POSTED_WRITE_ENABLE];
          nxt.sp_width = reg_wdata_i[POS_SP_WIDTH +: 4];
          nxt.sp_pgm = reg_wdata_i[POS_SP_PGM +: 4];
          nxt.sp_super = reg_wdata_i[POS_SP_SUPER +: 4];
          nxt.sp_base = reg_wdata_i[POS_SP_BASE +: 6];
          nxt.sp_las = reg_wdata_i[POS_LAS];
        end
        OFS_IMG4_CTL: begin
          nxt.i4_en = reg_wdata_i[POS_EN];
          nxt.i4_posted_write_enable = reg_wdata_i[POS_POSTED_WRITE_ENABLE];
          nxt.i4_width = reg_wdata_i[POS_I4_WIDTH +: 2];
          nxt.i4_space = reg_wdata_i[POS_I4_SPACE +: 3];
          nxt.i4_pgm = reg_wdata_i[POS_I4_PGM];
          nxt.i4_super = reg_wdata_i[POS_I4_SUPER];
          nxt.i4_vct = reg_wdata_i[POS_I4_VCT];
          nxt.i4_las = reg_wdata_i[POS_LAS];
        end
        OFS_IMG4_BASE: nxt.i4_base = reg_wdata_i[31:POS_PAGE];
        OFS_IMG4_BOUND: nxt.i4_bound = reg_wdata_i[31:POS_PAGE];
        OFS_IMG4_OFS: nxt.i4_ofs = reg_wdata_i[31:POS_PAGE];
        default: ; // read-only or unmapped: ignored
      endcase
    end
    // register reads, data stand one cycle later only
    nxt.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_MISC: begin
          nxt.rdata[POS_COMPAT +: 4] = r.compat;
          nxt.rdata[POS_CWT +: 3] = r.coupled_window_timer;
        end
        OFS_SPECIAL: begin
          nxt.rdata[POS_EN] = r.sp_en;
          nxt.rdata[POS_POSTED_WRITE_ENABLE] = r.sp_posted_write_enable;
          nxt.rdata[POS_SP_WIDTH +: 4] = r.sp_width;
          nxt.rdata[POS_SP_PGM +: 4] = r.sp_pgm;
          nxt.rdata[POS_SP_SUPER +: 4] = r.sp_super;
          nxt.rdata[POS_SP_BASE +: 6] = r.sp_base;
          nxt.rdata[POS_LAS] = r.sp_las;
        end
        OFS_CMD_ERR: begin
          nxt.rdata[POS_CMD +: 4] = log_cmd;
          nxt.rdata[POS_MERR] = log_merr;
          nxt.rdata[POS_LVALID] = log_valid;
        end
        OFS_ADDR_ERR: nxt.rdata = log_addr;
        OFS_IMG4_CTL: begin
          nxt.rdata[POS_EN] = r.i4_en;
          nxt.rdata[POS_POSTED_WRITE_ENABLE] = r.i4_posted_write_enable;
          nxt.rdata[POS_I4_WIDTH +: 2] = r.i4_width;
          nxt.rdata[POS_I4_SPACE +: 3] = r.i4_space;
          nxt.rdata[POS_I4_PGM] = r.i4_pgm;
          nxt.rdata[POS_I4_SUPER] = r.i4_super;
          nxt.rdata[POS_I4_VCT] = r.i4_vct;
          nxt.rdata[POS_LAS] = r.i4_las;
        end
        OFS_IMG4_BASE: nxt.rdata[31:POS_PAGE] = r.i4_base;
        OFS_IMG4_BOUND: nxt.rdata[31:POS_PAGE] = r.i4_bound;
        OFS_IMG4_OFS: nxt.rdata[31:POS_PAGE] = r.i4_ofs;
        default: nxt.rdata = '0; // unmapped reads as zero
      endcase
    end
    // decode results, refreshed on every address phase
    if (req_i) begin
      nxt.dvalid = 1'b1;
      nxt.c_sp = sp_hit;
      nxt.c_i4 = i4_hit;
      nxt.posted = 1'b0;
      nxt.vaddr = '0;
      nxt.am = AM_NONE;
      nxt.vwidth = W8;
      nxt.blk = 1'b0;
      nxt.mblt = 1'b0;
      if (i4_hit) begin
        // io space never posts
        nxt.posted = r.i4_posted_write_enable && !r.i4_las;
        nxt.vaddr = {page + r.i4_ofs, pci_addr_i[11:0]};
        nxt.vwidth = r.i4_width;
        nxt.blk = r.i4_vct && i4_wide && (r.i4_width != W64);
        nxt.mblt = i4_wide && (r.i4_width == W64);
        nxt.am = am_code(r.i4_space, r.i4_super, r.i4_pgm,
                         nxt.blk, nxt.mblt);
      end else if (sp_hit) begin
        nxt.posted = r.sp_posted_write_enable && !r.sp_las;
        nxt.vwidth = r.sp_width[region] ? W32 : W16;
        if (sp_a16) begin
          nxt.vaddr = {16'h0000, pci_addr_i[15:0]};
          nxt.am = am_code(SP_A16, r.sp_super[region], 1'b0,
                           1'b0, 1'b0);
        end else begin
          nxt.vaddr = {8'h00, pci_addr_i[23:0]};
          nxt.am = am_code(SP_A24, r.sp_super[region], r.sp_pgm[region],
                           1'b0, 1'b0); // no block codes
        end
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
      r.i4_width <= RST_I4_WIDTH;
    end else if (ce_i) begin
      r <= nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  assign reg_rdata_o = r.rdata;
  assign dec_valid_o = r.dvalid;
  assign claim_special_o = r.c_sp;
  assign claim_img4_o = r.c_i4;
  assign posted_o = r.posted;
  assign vme_addr_o = r.vaddr;
  assign vme_am_o = r.am;
  assign vme_width_o = r.vwidth;
  assign block_ok_o = r.blk;
  assign mblt_ok_o = r.mblt;
  assign vme_own_o = win.own; // timer's own flop

endmodule : slave_image_ctrl

// >>> bench/slave_image_ctrl_monitor.sv
`timescale 1ns/100ps
module slave_image_ctrl_monitor
  import bridge_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic ce_i, // enable
  input wire logic req_i, // request
  input wire logic [31:0] pci_addr_i, // address
  input wire logic other_hit_i, // other image
  input wire logic coup_start_i, // coupled start
  input wire logic dec_valid_o, // result valid
  input wire logic claim_special_o, // special claim
  input wire logic claim_img4_o, // image 4 claim
  input wire logic [31:0] vme_addr_o, // vme address
  input wire logic [5:0] vme_am_o, // modifier
  input wire logic block_ok_o, // block ok
  input wire logic mblt_ok_o, // mblt ok
  input wire logic vme_own_o // ownership
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // a special result, then the region part that caused it
  sequence sp_hit;
    dec_valid_o && claim_special_o;
  endsequence
  sequence top64;
    $past(pci_addr_i[23:16]) == A16_TOP;
  endsequence
  AST_DEC_LAT:
    assert property (req_i && ce_i |=> dec_valid_o) else $error("late result");
  AST_DEC_IDLE:
    assert property (!req_i |=> !dec_valid_o) else $error("stray result");
  AST_OTHER_WINS:
    assert property (dec_valid_o && $past(other_hit_i) |-> !claim_special_o)
      else $error("special beat other image");
  AST_ONE_CLAIM:
    assert property (!(claim_special_o && claim_img4_o))
      else $error("two claims");
  AST_SP_NO_BLOCK:
    assert property (sp_hit |-> !block_ok_o && !mblt_ok_o)
      else $error("special block");
  AST_SP_A16:
    assert property (sp_hit ##0 top64 |-> vme_am_o inside {6'h29, 6'h2d}
      && vme_addr_o == {16'h0, $past(pci_addr_i[15:0])}) else $error("a16");
  AST_SP_A24:
    assert property (sp_hit ##0 $past(pci_addr_i[23:16]) != A16_TOP |->
      vme_addr_o == {8'h0, $past(pci_addr_i[23:0])}) else $error("a24");
  AST_OWN_TAKE:
    assert property (coup_start_i |=> vme_own_o) else $error("no ownership");
endmodule : slave_image_ctrl_monitor

// >>> bench/coupled_initiator.sv
`timescale 1ns/100ps
module coupled_initiator (
  input wire logic clk_i, // clock
  input wire logic go_i, // one coupled cycle
  input wire logic [3:0] lat_i, // start to done
  output logic start_o = 1'b0, // start pulse
  output logic done_o = 1'b0 // done pulse
);
  int cnt = 0; // cycles until done
  // prompt or slow answer, as lat_i asks
  always @(posedge clk_i) begin
    start_o <= go_i;
    done_o <= cnt == 1;
    if (go_i) cnt <= lat_i + 1;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : coupled_initiator

// >>> bench/slave_image_ctrl_tb.sv
`timescale 1ns/100ps
module slave_image_ctrl_tb;
  import bridge_pkg::*;
  logic clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0, req_i = 1'b0, pci_io_i = 1'b0, other_hit_i = 1'b0;
  logic err_i = 1'b0, go_i = 1'b0, rd_d = 1'b0, coup_start_i, coup_done_i;
  logic dec_valid_o, claim_special_o, claim_img4_o, posted_o, vme_own_o;
  logic block_ok_o, mblt_ok_o;
  logic [11:0] reg_addr_i = 12'h0;
  logic [31:0] reg_wdata_i = 32'h0, pci_addr_i = 32'h0, err_addr_i = 32'h0;
  logic [31:0] reg_rdata_o, vme_addr_o, ea, rq[$];
  logic [3:0] err_cmd_i = 4'h0, lat_i = 4'h1;
  logic [5:0] vme_am_o;
  logic [1:0] vme_width_o;
  logic [44:0] e, dq[$];
  int fail_count = 0, tests_run = 0, cyc = 0;
  int nt[7] = '{0, 16, 32, 64, 128, 246, 512}; // hold per code
  logic [5:0] at[8] = '{6'h29, 6'h3b, 6'h0b, 6'h0, 6'h0, 6'h2f, 6'h10, 6'h11};
  wire logic [44:0] got = {claim_special_o, claim_img4_o, posted_o,
    block_ok_o, mblt_ok_o, vme_width_o, vme_am_o, vme_addr_o};
  slave_image_ctrl dut (.*);
  coupled_initiator far (.clk_i, .go_i, .lat_i, .start_o(coup_start_i),
    .done_o(coup_done_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [44:0] s, input logic [44:0] x);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    rq.push_back(x);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  // no claim expected: only the claim bits are compared
  task automatic dec(input logic [31:0] a, input logic io,
      input logic [44:0] x);
    dq.push_back(x);
    pci_addr_i <= a;
    pci_io_i <= io;
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    @(posedge clk_i);
  endtask : dec
  task automatic err(input logic [3:0] c, input logic [31:0] a);
    err_cmd_i <= c;
    err_addr_i <= a;
    err_i <= 1'b1;
    @(posedge clk_i);
    err_i <= 1'b0;
  endtask : err
  task automatic cpl(input logic [3:0] l);
    lat_i <= l;
    go_i <= 1'b1;
    @(posedge clk_i);
    go_i <= 1'b0;
    do @(posedge clk_i); while (coup_done_i !== 1'b1);
  endtask : cpl
  // ownership sampled mid-cycle, after the edge has settled
  task automatic och(input int n, input logic x);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    chk({44'h0, vme_own_o}, {44'h0, x});
    @(posedge clk_i);
  endtask : och
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i;
    cyc <= cyc + 1;
    if (rd_d) chk({13'h0, reg_rdata_o}, {13'h0, rq.pop_front()});
    if (dec_valid_o) begin
      e = dq.pop_front();
      chk(e[44:43] != 2'b00 ? got : {got[44:43], 43'h0}, e);
    end
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    void'($urandom(46));
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(OFS_MISC, 32'h0);
    rd(OFS_CMD_ERR, 32'h7000_0000);
    rd(OFS_IMG4_CTL, 32'h0080_0000);
    rd(12'h000, 32'h0);
    ea = $urandom;
    wr(OFS_MISC, ea);
    rd(OFS_MISC, ea & 32'hf700_0000);
    wr(OFS_IMG4_CTL, ea);
    rd(OFS_IMG4_CTL, ea & 32'hc0c7_5101);
    err(4'h3, ea);
    rd(OFS_ADDR_ERR, ea);
    err(4'hb, ~ea);
    wr(OFS_CMD_ERR, 32'h0);
    wr(OFS_ADDR_ERR, 32'h0);
    rd(OFS_CMD_ERR, 32'h3880_0000);
    rd(OFS_ADDR_ERR, ea);
    wr(OFS_CMD_ERR, 32'h0080_0000);
    rd(OFS_CMD_ERR, 32'h3000_0000);
    err(4'h6, ~ea);
    rd(OFS_ADDR_ERR, ~ea);
    wr(OFS_IMG4_BASE, 32'h1000_0000);
    wr(OFS_IMG4_BOUND, 32'h2000_0000);
    wr(OFS_IMG4_OFS, 32'hf000_0000);
    wr(OFS_IMG4_CTL, 32'h4082_0000);
    dec(32'h1000_0abc, 1'b0, 45'h0);
    wr(OFS_IMG4_CTL, 32'hc082_0000);
    dec(32'h1fff_f004, 1'b0,
      {7'b0110010, 6'h09, 32'h0fff_f004});
    dec(32'h2000_0000, 1'b0, 45'h0);
    dec(32'h0fff_f000, 1'b0, 45'h0);
    wr(OFS_IMG4_CTL, 32'hc082_0001);
    dec(32'h1000_0000, 1'b1, {7'b0100010, 6'h09, 32'h0});
    for (int i = 0; i < 8; i++) begin
      wr(OFS_IMG4_CTL, 32'h8080_0100 | (i << 16));
      dec(32'h1000_0abc, 1'b0, {3'b010, i == 1 || i == 2, 1'b0, 2'h2, at[i],
        32'h0000_0abc});
    end
    wr(OFS_IMG4_CTL, 32'h80c1_0000);
    dec(32'h1000_0abc, 1'b0, {7'b0100111, 6'h38, 32'h0abc});
    wr(OFS_SPECIAL, 32'h8040_f81c);
    dec(32'h1c00_0010, 1'b0,
      {7'b0100111, 6'h38, 32'h0c00_0010});
    wr(OFS_IMG4_CTL, 32'h0);
    dec(32'h1eff_1234, 1'b0,
      {7'b1000010, 6'h29, 32'h1234});
    dec(32'h1e12_3456, 1'b0,
      {7'b1000010, 6'h3a, 32'h12_3456});
    dec(32'h1fff_0010, 1'b0, {7'b1000001, 6'h2d, 32'h0010});
    dec(32'h1f00_0020, 1'b0, {7'b1000001, 6'h3e, 32'h0020});
    dec(32'h2000_0000, 1'b0, 45'h0);
    dec(32'h1c00_0000, 1'b1, 45'h0);
    other_hit_i <= 1'b1;
    dec(32'h1c00_0000, 1'b0, 45'h0);
    wr(OFS_MISC, 32'h0);
    cpl(4'h2);
    och(1, 1'b0);
    wr(OFS_MISC, 32'h0100_0000);
    cpl(4'h1);
    och(8, 1'b1);
    cpl(4'h3);
    och(13, 1'b1);
    for (int i = 1; i < 7; i++) begin
      wr(OFS_MISC, i << 24);
      cpl(4'($urandom_range(8, 1)));
      och(nt[i] - 3, 1'b1);
      och(5, 1'b0);
    end
    close_out();
  end
endmodule : slave_image_ctrl_tb
bind slave_image_ctrl slave_image_ctrl_monitor mon (.*);
